// ---- shared/wdrc_regs.vh ----
// Register map, field positions, reset values and counts of the watchdog
`ifndef WDRC_REGS_VH
`define WDRC_REGS_VH

// Byte addresses on the register bus
`define WDRC_ADDR_CAUSE 4'h0
`define WDRC_ADDR_CTRL 4'h4

// Reset-cause status fields
`define WDRC_CAUSE_POR 0
`define WDRC_CAUSE_EXT 1
`define WDRC_CAUSE_BOD 2
`define WDRC_CAUSE_WDG 3
`define WDRC_CAUSE_RESET 4'h1

// Supervision control fields
`define WDRC_CTRL_PSEL0 0
`define WDRC_CTRL_PSEL2 2
`define WDRC_CTRL_WDE 3
`define WDRC_CTRL_PROTECTED_CHANGE_ENABLE 4
`define WDRC_CTRL_PSEL3 5
`define WDRC_CTRL_IE 6
`define WDRC_CTRL_IF 7
`define WDRC_PSEL_RESET 4'h0

// Timed change window in system clocks
`define WDRC_CHG_CYCLES 3'h4

// Period table: code 0 is 2048 oscillator cycles, doubling up to code 9
`define WDRC_PSEL_MAX 4'h9
`define WDRC_BASE_CYCLES 21'h000800

// Bus responses
`define WDRC_RESP_OKAY 2'h0
`define WDRC_RESP_SLVERR 2'h2

`endif

// ---- sim/watchdog_with_reset_cause_flags_test.sv ----
// Self-checking bench for the watchdog with reset-cause flags
module watchdog_with_reset_cause_flags_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 0, rst_n_in = 0, kick = 0, svc = 0;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_arvalid_in = 0;
    logic [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic [31:0] s_axi_wdata_in = 32'h0;
    logic s_axi_bready_in = 1, s_axi_rready_in = 1;
    logic ext_reset_in = 0, brownout_reset_in = 0, always_on_fuse_in = 0;
    logic brownout_fuse_en_in = 0, comparator_reference_select_in = 0;
    logic converter_enable_in = 0;
    wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    wire s_axi_arready_out, s_axi_rvalid_out;
    wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    wire restart_in, irq_ack_in, osc_in;
    wire timeout_irq_out, sys_reset_out, reference_enable_out;
    int n_errors = 0, samples_checked = 0;
    always #2 clk_in = ~clk_in;
    wdrc_core_model i_wdrc_core_model (.clk_in, .kick_in(kick), .svc_in(svc),
        .irq_in(timeout_irq_out), .osc_out(osc_in), .restart_out(restart_in),
        .irq_ack_out(irq_ack_in));
    wdrc_top i_wdrc_top (.*);
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 60000)
        begin
            n_errors++;
            $display("ERROR %0t wait ran out", $time);
            wrap_up;
        end
    endtask
    // Response channels keep ready high, so answers are taken on arrival
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {24'h0, d};
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_awready_out)
                s_axi_awvalid_in <= 0;
            if (s_axi_wready_out)
                s_axi_wvalid_in <= 0;
            hang(++n);
        end
        while (!s_axi_bvalid_out);
        chk({30'h0, s_axi_bresp_out}, a > 4'h4 ? 32'h2 : 32'h0);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        int n;
        n = 0;
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_arready_out)
                s_axi_arvalid_in <= 0;
            hang(++n);
        end
        while (!s_axi_rvalid_out);
        chk(s_axi_rdata_out, e);
        chk({30'h0, s_axi_rresp_out}, a > 4'h4 ? 32'h2 : 32'h0);
    endtask
    task automatic wait_for(input bit rst_sel, output int c);
        c = 0;
        do
        begin
            @(posedge clk_in);
            hang(++c);
        end
        while (!(rst_sel ? sys_reset_out : timeout_irq_out));
    endtask
    task automatic t_cause;
        rd(4'h0, 32'h1);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        ext_reset_in <= 1;
        brownout_reset_in <= 1;
        repeat (3) @(posedge clk_in);
        ext_reset_in <= 0;
        brownout_reset_in <= 0;
        repeat (4) @(posedge clk_in);
        rd(4'h0, 32'h7);
        wr(4'h0, 8'hfe);
        rd(4'h0, 32'h6);
        wr(4'h0, 8'hf0);
        rd(4'h0, 32'h0);
        $display("cause test done");
    endtask
    task automatic t_ref;
        for (int i = 0; i < 8; i++)
        begin
            {brownout_fuse_en_in, comparator_reference_select_in,
                converter_enable_in} <= i[2:0];
            repeat (6) @(posedge clk_in);
            chk({31'h0, reference_enable_out}, {31'h0, |i[2:0]});
        end
        $display("reference test done");
    endtask
    task automatic t_irq;
        int c;
        wr(4'h4, 8'h40);
        repeat (8000) @(posedge clk_in);
        kick <= 1;
        @(posedge clk_in);
        kick <= 0;
        wait_for(0, c);
        chk({31'h0, c >= 16370 && c <= 16400}, 32'h1);
        rd(4'h4, 32'hc0);
        rd(4'h0, 32'h0);
        svc <= 1;
        repeat (6) @(posedge clk_in);
        chk({31'h0, timeout_irq_out}, 32'h0);
        rd(4'h4, 32'h40);
        svc <= 0;
        wr(4'h4, 8'h00);
        $display("interrupt test done");
    endtask
    task automatic t_comb;
        int c;
        wr(4'h4, 8'h48);
        wait_for(0, c);
        chk({31'h0, c >= 16370 && c <= 16400}, 32'h1);
        rd(4'h4, 32'hc8);
        wait_for(1, c);
        chk({31'h0, c >= 16370 && c <= 16400}, 32'h1);
        repeat (2) @(posedge clk_in);
        chk({31'h0, timeout_irq_out}, 32'h0);
        rd(4'h0, 32'h8);
        rd(4'h4, 32'h08);
        wr(4'h4, 8'h18);
        wr(4'h4, 8'h00);
        rd(4'h4, 32'h08);
        wr(4'h0, 8'h00);
        rd(4'h0, 32'h0);
        // Follow-up arrives after the window has shut
        wr(4'h4, 8'h18);
        repeat (6) @(posedge clk_in);
        wr(4'h4, 8'h01);
        rd(4'h4, 32'h08);
        wr(4'h4, 8'h18);
        wr(4'h4, 8'h21);
        rd(4'h4, 32'h21);
        $display("combined test done");
    endtask
    task automatic t_fuse;
        always_on_fuse_in <= 1;
        repeat (4) @(posedge clk_in);
        wr(4'h4, 8'h40);
        rd(4'h4, 32'h29);
        always_on_fuse_in <= 0;
        repeat (4) @(posedge clk_in);
        $display("fuse test done");
    endtask
    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1;
        t_cause;
        t_ref;
        t_irq;
        t_comb;
        t_fuse;
        wrap_up;
    end
endmodule // watchdog_with_reset_cause_flags_test

// ---- sim/wdrc_core_model.sv ----
// Core-side partner: slow oscillator, restart requests, vector service
module wdrc_core_model #(
    parameter int OSC_HALF = 16
) (
    // System clock, requests from the bench and the watchdog interrupt
    input wire logic clk_in,
    input wire logic kick_in,
    input wire logic svc_in,
    input wire logic irq_in,
    // Towards the watchdog
    output logic osc_out,
    output logic restart_out,
    output logic irq_ack_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic kick_r = 1'b0;
    // Free-running and phase-offset, so ticks keep a fixed phase between clock edges
    initial
    begin
        osc_out = 1'b0;
        #1.3;
        forever #(OSC_HALF) osc_out = ~osc_out;
    end
    always @(posedge clk_in)
    begin
        kick_r <= kick_in;
        restart_out <= kick_in && !kick_r;
        // One vector entry per pending interrupt while service is allowed
        irq_ack_out <= svc_in && irq_in && !irq_ack_out;
    end
endmodule // wdrc_core_model

// ---- sim/wdrc_top_sva.sv ----
// Checker on the watchdog top-level ports
module wdrc_top_sva (
    // Clock, reset and read path
    input wire clk_in,
    input wire rst_n_in,
    input wire [3:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    input wire s_axi_arready_out,
    input wire [31:0] s_axi_rdata_out,
    input wire s_axi_rvalid_out,
    // Core, oscillator, fuse and analog inputs
    input wire restart_in,
    input wire irq_ack_in,
    input wire osc_in,
    input wire always_on_fuse_in,
    input wire brownout_fuse_en_in,
    input wire comparator_reference_select_in,
    input wire converter_enable_in,
    // Outputs
    input wire timeout_irq_out,
    input wire sys_reset_out,
    input wire reference_enable_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] ar_r;
    logic [2:0] osc_r;
    logic [11:0] ticks_r;
    // Ticks since the last restart, reset or first interrupt of a period
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ar_r <= 4'h0;
            osc_r <= 3'h0;
            ticks_r <= 12'h000;
        end
        else
        begin
            osc_r <= {osc_r[1:0], osc_in};
            if (s_axi_arvalid_in && s_axi_arready_out)
                ar_r <= s_axi_araddr_in;
            if (restart_in || sys_reset_out || $rose(timeout_irq_out))
                ticks_r <= 12'h000;
            else if (osc_r[2:1] == 2'b01 && !ticks_r[11])
                ticks_r <= ticks_r + 12'h001;
        end
    end
    property p_cause_hi;
        s_axi_rvalid_out && ar_r == 4'h0 |-> s_axi_rdata_out[31:4] == 28'h0;
    endproperty
    a_cause_hi: assert property (p_cause_hi) else $error("cause hi");
    property p_ref_on;
        comparator_reference_select_in || converter_enable_in
            |=> reference_enable_out;
    endproperty
    a_ref_on: assert property (p_ref_on) else $error("ref not on");
    property p_ref_off;
        (!brownout_fuse_en_in && !comparator_reference_select_in
            && !converter_enable_in) [*5] |=> !reference_enable_out;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("ref on");
    property p_rst_pulse;
        sys_reset_out |=> !sys_reset_out;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("stuck");
    property p_fuse;
        always_on_fuse_in [*4] |-> !timeout_irq_out;
    endproperty
    a_fuse: assert property (p_fuse) else $error("irq under fuse");
    property p_restart;
        restart_in |-> ##3 !sys_reset_out [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("rst at kick");
    property p_ack;
        irq_ack_in && timeout_irq_out |=> !timeout_irq_out;
    endproperty
    a_ack: assert property (p_ack) else $error("irq after ack");
    property p_period;
        sys_reset_out |-> ticks_r >= 12'h7f8;
    endproperty
    a_period: assert property (p_period) else $error("early rst");
    c_reset: cover property (sys_reset_out);
    c_irq: cover property ($rose(timeout_irq_out));
    c_ack: cover property (irq_ack_in && timeout_irq_out);
endmodule // wdrc_top_sva
bind wdrc_top wdrc_top_sva i_wdrc_top_sva (
    .clk_in, .rst_n_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out,
    .restart_in, .irq_ack_in, .osc_in, .always_on_fuse_in,
    .brownout_fuse_en_in, .comparator_reference_select_in,
    .converter_enable_in, .timeout_irq_out, .sys_reset_out,
    .reference_enable_out
);

// ---- verilog/wdrc_period_timer.v ----
// Oscillator-tick counter that flags expiry of the selected period
module wdrc_period_timer (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Control
    input wire run_in,
    input wire restart_in,
    input wire tick_in,
    input wire [3:0] period_sel_in,
    // Expiry
    output reg expire_out
);
`include "wdrc_regs.vh"

    reg [20:0] count_r;
    reg [20:0] count_nxt;
    wire [3:0] sel;
    wire [20:0] limit;

    // Reserved codes behave as the longest period
    assign sel = (period_sel_in > `WDRC_PSEL_MAX) ? `WDRC_PSEL_MAX :
        period_sel_in;
    assign limit = `WDRC_BASE_CYCLES << sel;

    always @*
    begin
        count_nxt = count_r;
        if (restart_in || !run_in)
            count_nxt = 21'h000000;
        else if (tick_in)
            count_nxt = (count_r + 21'h000001 >= limit) ? 21'h000000 :
                count_r + 21'h000001;
    end

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_r <= 21'h000000;
            expire_out <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            expire_out <= run_in && !restart_in && tick_in &&
                (count_r + 21'h000001 >= limit);
        end
    end
endmodule // wdrc_period_timer

// ---- verilog/wdrc_sync2.v ----
// Two-stage synchroniser for signals arriving from outside the clock domain
module wdrc_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Data
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // wdrc_sync2

// ---- verilog/wdrc_top.v ----
// Watchdog with reset-cause flags, reference enable and AXI4-Lite registers
//
// Local design decisions: the address map and the AXI4-Lite register port.
module wdrc_top (
    // Clock and power-on reset
    input wire clk_in,
    input wire rst_n_in,
    // AXI4-Lite write address and data
    input wire [3:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    // AXI4-Lite read
    input wire [3:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    // Core side: restart instruction and vector service, one-cycle pulses
    input wire restart_in,
    input wire irq_ack_in,
    // Pins and fuses from outside the clock domain
    input wire osc_in,
    input wire ext_reset_in,
    input wire brownout_reset_in,
    input wire always_on_fuse_in,
    input wire brownout_fuse_en_in,
    // Same-clock analog controls
    input wire comparator_reference_select_in,
    input wire converter_enable_in,
    // Outputs
    output wire timeout_irq_out,
    output reg sys_reset_out,
    output reg reference_enable_out
);
`include "wdrc_regs.vh"

    wire [4:0] pins_s;
    wire osc_s;
    wire ext_s;
    wire bod_s;
    wire fuse_s;
    wire bod_fuse_s;
    reg osc_d_r;
    reg ext_d_r;
    reg bod_d_r;
    wire osc_tick;
    wire ext_event;
    wire bod_event;

    reg [3:0] cause_r;
    reg [3:0] cause_nxt;
    reg if_r;
    reg if_nxt;
    reg ie_r;
    reg ie_nxt;
    reg wde_r;
    reg wde_nxt;
    reg [3:0] psel_r;
    reg [3:0] psel_nxt;
    reg [2:0] window_r;
    reg [2:0] window_nxt;
    wire wde_eff;
    wire ie_eff;
    wire run;
    wire expire;
    wire reset_action;
    wire irq_action;
    wire [7:0] ctrl_rd;

    reg aw_full_r;
    reg [3:0] aw_addr_r;
    reg w_full_r;
    reg [7:0] w_data_r;
    reg w_lane_r;
    wire wr_do;
    wire wr_cause;
    wire wr_ctrl;
    wire [7:0] wd;

    wdrc_sync2 #(
        .WIDTH(5)
    ) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in({osc_in, ext_reset_in, brownout_reset_in,
            always_on_fuse_in, brownout_fuse_en_in}),
        .sync_out(pins_s)
    );

    assign osc_s = pins_s[4];
    assign ext_s = pins_s[3];
    assign bod_s = pins_s[2];
    assign fuse_s = pins_s[1];
    assign bod_fuse_s = pins_s[0];

    // Edge detection runs only on the synchronised copies
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            osc_d_r <= 1'b0;
            ext_d_r <= 1'b0;
            bod_d_r <= 1'b0;
        end
        else
        begin
            osc_d_r <= osc_s;
            ext_d_r <= ext_s;
            bod_d_r <= bod_s;
        end
    end

    assign osc_tick = osc_s && !osc_d_r;
    assign ext_event = ext_s && !ext_d_r;
    assign bod_event = bod_s && !bod_d_r;

    // Effective mode bits as the hardware sees and software reads them
    assign wde_eff = fuse_s || wde_r ||
        cause_r[`WDRC_CAUSE_WDG];
    assign ie_eff = ie_r && !fuse_s;
    assign run = wde_eff || ie_eff;

    wdrc_period_timer u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .run_in(run),
        .restart_in(restart_in),
        .tick_in(osc_tick),
        .period_sel_in(psel_r),
        .expire_out(expire)
    );

    // Combined mode resets at an expiry while the first interrupt's flag is still set
    assign reset_action = expire && wde_eff &&
        (!ie_eff || if_r);
    assign irq_action = expire && ie_eff && !if_r;
    assign timeout_irq_out = if_r && ie_eff;

    // Bus write path: address and data taken in either order
    assign s_axi_awready_out = !aw_full_r && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_full_r && !s_axi_bvalid_out;
    assign wr_do = aw_full_r && w_full_r && !s_axi_bvalid_out;
    assign wr_cause = wr_do && w_lane_r && (aw_addr_r == `WDRC_ADDR_CAUSE);
    assign wr_ctrl = wr_do && w_lane_r && (aw_addr_r == `WDRC_ADDR_CTRL);
    assign wd = w_data_r;

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_full_r <= 1'b0;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `WDRC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_full_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr_in[3:2], 2'b00};
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata_in[7:0];
                w_lane_r <= s_axi_wstrb_in[0];
            end
            if (wr_do)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= (aw_addr_r == `WDRC_ADDR_CAUSE ||
                    aw_addr_r == `WDRC_ADDR_CTRL) ? `WDRC_RESP_OKAY :
                    `WDRC_RESP_SLVERR;
            end
            else if (s_axi_bready_in)
                s_axi_bvalid_out <= 1'b0;
        end
    end

    // Watchdog and cause state; hardware sets win over software clears
    always @*
    begin
        cause_nxt = cause_r;
        if_nxt = if_r;
        ie_nxt = ie_r;
        wde_nxt = wde_r;
        psel_nxt = psel_r;
        window_nxt = (window_r != 3'h0) ? window_r - 3'h1 : 3'h0;
        if (wr_cause)
            cause_nxt = cause_r & wd[3:0];
        if (wr_ctrl)
        begin
            if (wd[`WDRC_CTRL_IF])
                if_nxt = 1'b0;
            ie_nxt = wd[`WDRC_CTRL_IE] && !fuse_s;
            if (wd[`WDRC_CTRL_PROTECTED_CHANGE_ENABLE] && wd[`WDRC_CTRL_WDE])
            begin
                wde_nxt = 1'b1;
                window_nxt = `WDRC_CHG_CYCLES;
            end
            else if (window_r != 3'h0 && !wd[`WDRC_CTRL_PROTECTED_CHANGE_ENABLE])
            begin
                wde_nxt = wd[`WDRC_CTRL_WDE];
                psel_nxt = {wd[`WDRC_CTRL_PSEL3],
                    wd[`WDRC_CTRL_PSEL2:`WDRC_CTRL_PSEL0]};
                window_nxt = 3'h0;
            end
            else
                wde_nxt = wde_r || wd[`WDRC_CTRL_WDE];
        end
        if (irq_ack_in && timeout_irq_out)
        begin
            if_nxt = 1'b0;
            if (wde_eff)
                ie_nxt = 1'b0;
        end
        if (irq_action)
            if_nxt = 1'b1;
        // Non-power-on resets restore control defaults but keep reset enable
        if (reset_action || ext_event || bod_event)
        begin
            if_nxt = 1'b0;
            ie_nxt = 1'b0;
            psel_nxt = `WDRC_PSEL_RESET;
            window_nxt = 3'h0;
            wde_nxt = wde_r || reset_action;
        end
        if (reset_action)
            cause_nxt[`WDRC_CAUSE_WDG] = 1'b1;
        if (bod_event)
            cause_nxt[`WDRC_CAUSE_BOD] = 1'b1;
        if (ext_event)
            cause_nxt[`WDRC_CAUSE_EXT] = 1'b1;
    end

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cause_r <= `WDRC_CAUSE_RESET;
            if_r <= 1'b0;
            ie_r <= 1'b0;
            wde_r <= 1'b0;
            psel_r <= `WDRC_PSEL_RESET;
            window_r <= 3'h0;
            sys_reset_out <= 1'b0;
            reference_enable_out <= 1'b0;
        end
        else
        begin
            cause_r <= cause_nxt;
            if_r <= if_nxt;
            ie_r <= ie_nxt;
            wde_r <= wde_nxt;
            psel_r <= psel_nxt;
            window_r <= window_nxt;
            sys_reset_out <= reset_action;
            reference_enable_out <= bod_fuse_s ||
                comparator_reference_select_in || converter_enable_in;
        end
    end

    assign ctrl_rd = {if_r, ie_eff, psel_r[3], (window_r != 3'h0), wde_eff,
        psel_r[2:0]};

    // Bus read path: one-cycle answer
    assign s_axi_arready_out = !s_axi_rvalid_out;

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `WDRC_RESP_OKAY;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= `WDRC_RESP_OKAY;
            case ({s_axi_araddr_in[3:2], 2'b00})
                `WDRC_ADDR_CAUSE:
                    s_axi_rdata_out <= {28'h0000000, cause_r};
                `WDRC_ADDR_CTRL: s_axi_rdata_out <= {24'h000000, ctrl_rd};
                default:
                begin
                    s_axi_rdata_out <= 32'h00000000;
                    s_axi_rresp_out <= `WDRC_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
    end
endmodule // wdrc_top
